// ---- verilog/msc_pkg.sv ----
// Constants for the mode switch checker: register map, field layout,
// error codes and reset values. Imported whole by the checker module.
`default_nettype none
package msc_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [5:0] MSC_OFF_CTRL = 6'h00;
  localparam logic [5:0] MSC_OFF_OUT_MASK = 6'h04;
  localparam logic [5:0] MSC_OFF_ERR_CODE = 6'h08;
  localparam logic [5:0] MSC_OFF_ERR_AXIS_A = 6'h0C;
  localparam logic [5:0] MSC_OFF_ERR_AXIS_B = 6'h10;
  localparam logic [5:0] MSC_OFF_STATUS = 6'h14;
  localparam logic [5:0] MSC_OFF_IRQ_STAT = 6'h18;
  localparam logic [5:0] MSC_OFF_IRQ_CLR = 6'h1C;
  localparam logic [5:0] MSC_OFF_IRQ_EN = 6'h20;
  // ==========================================================
  // Control field positions
  localparam int MSC_CTRL_REQ = 0;
  localparam int MSC_CTRL_PERMIT = 1;
  localparam int MSC_CTRL_SERVO = 2;
  localparam int MSC_CTRL_LEGACY = 3;
  localparam int MSC_CTRL_W = 4;
  // Interrupt bits
  localparam int MSC_IRQ_DONE = 0;
  localparam int MSC_IRQ_ERR = 1;
  localparam int MSC_IRQ_W = 2;
  // ==========================================================
  // Error codes
  localparam logic [15:0] MSC_CODE_NONE = 16'h0000;
  localparam logic [15:0] MSC_CODE_NOT_STOPPED = 16'h0001;
  localparam logic [15:0] MSC_CODE_BACK_REAL = 16'h0100;
  localparam logic [15:0] MSC_CODE_PROGRAM = 16'h0200;
  localparam logic [15:0] MSC_CODE_NOT_READY = 16'h0201;
  localparam logic [15:0] MSC_CODE_SERVO_OFF = 16'h0202;
  // ==========================================================
  // Reset values and bus answers
  localparam logic [MSC_CTRL_W-1:0] MSC_CTRL_RST = 4'h0;
  localparam logic [31:0] MSC_MASK_RST = 32'hFFFFFFFF;
  localparam logic [1:0] MSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] MSC_RESP_SLVERR = 2'h2;
  // ==========================================================
  // Current operating mode
  typedef enum logic [1:0] {
    MSC_REAL = 2'h1,
    MSC_VIRTUAL = 2'h2
  } msc_mode_t;
endpackage
`default_nettype wire

// ---- verilog/msc_mode_switch_checker.sv ----
// Real/virtual mode switch checker with AXI4-Lite registers.
// Assumes all inputs synchronous to clk; axis flags from the motion core.
`timescale 1ns/1ps
`default_nettype none
module msc_mode_switch_checker
  import msc_pkg::*;
#(
  parameter int NUM_AXES = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AXI4-Lite write
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Motion core state
  input wire logic [NUM_AXES-1:0] axisStartAccepted,
  input wire logic [NUM_AXES-1:0] virtualAxisStartAccepted,
  input wire logic [NUM_AXES-1:0] speedTorqueMode,
  input wire logic processorReadyDone,
  input wire logic mechProgramRegistered,
  input wire logic axisNumberMismatch,
  // Results
  output logic virtualModeActive,
  output logic irq
);
  // ==========================================================
  // Registers
  logic [MSC_CTRL_W-1:0] ctrl_q;
  logic [NUM_AXES-1:0] outAxisMask_q;
  logic [15:0] switchErrorCode_q;
  logic [NUM_AXES-1:0] errorAxisInfoA_q;
  logic [NUM_AXES-1:0] errorAxisInfoB_q;
  logic [MSC_IRQ_W-1:0] irqStatus_q;
  logic [MSC_IRQ_W-1:0] irqEnable_q;
  msc_mode_t mode_q;
  logic reqPrev_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  logic modeSwitchRequest;
  logic controllerRunPermit;
  logic allAxesServoOnCmd;
  logic legacyCheck;
  assign modeSwitchRequest = ctrl_q[MSC_CTRL_REQ];
  assign controllerRunPermit = ctrl_q[MSC_CTRL_PERMIT];
  assign allAxesServoOnCmd = ctrl_q[MSC_CTRL_SERVO];
  assign legacyCheck = ctrl_q[MSC_CTRL_LEGACY];

  // ==========================================================
  // Bus handshake
  logic wrFire;
  logic rdFire;
  logic [31:0] wrMask;
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_wready = s_axi_awready;
  assign wrFire = s_axi_awready;
  assign s_axi_arready = !rvalid_q;
  assign rdFire = s_axi_arvalid && s_axi_arready;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : gLane
      assign wrMask[lane*8 +: 8] = {8{s_axi_wstrb[lane]}};
    end
  endgenerate

  logic wrCtrl;
  logic wrMaskReg;
  logic wrIrqClr;
  logic wrIrqEn;
  logic wrKnown;
  assign wrCtrl = wrFire && (s_axi_awaddr == MSC_OFF_CTRL);
  assign wrMaskReg = wrFire && (s_axi_awaddr == MSC_OFF_OUT_MASK);
  assign wrIrqClr = wrFire && (s_axi_awaddr == MSC_OFF_IRQ_CLR);
  assign wrIrqEn = wrFire && (s_axi_awaddr == MSC_OFF_IRQ_EN);
  // Read-only registers accept writes silently
  assign wrKnown = (s_axi_awaddr <= MSC_OFF_IRQ_EN) && (s_axi_awaddr[1:0] == 2'h0);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= MSC_CTRL_RST;
    end else if (wrCtrl) begin
      ctrl_q <= (ctrl_q & ~wrMask[MSC_CTRL_W-1:0]) | (s_axi_wdata[MSC_CTRL_W-1:0] & wrMask[MSC_CTRL_W-1:0]);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      outAxisMask_q <= MSC_MASK_RST[NUM_AXES-1:0];
    end else if (wrMaskReg) begin
      outAxisMask_q <= (outAxisMask_q & ~wrMask[NUM_AXES-1:0]) | (s_axi_wdata[NUM_AXES-1:0] & wrMask[NUM_AXES-1:0]);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= MSC_RESP_OKAY;
    end else if (wrFire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wrKnown ? MSC_RESP_OKAY : MSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // Edge detection and checks
  logic riseEv;
  logic fallEv;
  logic [NUM_AXES-1:0] realBusy;
  logic [NUM_AXES-1:0] virtBusy;
  logic [15:0] riseCode;
  logic [15:0] fallCode;
  logic riseFail;
  logic fallFail;

  assign riseEv = modeSwitchRequest && !reqPrev_q;
  assign fallEv = !modeSwitchRequest && reqPrev_q;
  // Legacy firmware blocks on every axis; newer only on involved real axes, but on any virtual axis
  assign realBusy = legacyCheck ? (axisStartAccepted | virtualAxisStartAccepted)
                                : (axisStartAccepted & outAxisMask_q);
  assign virtBusy = legacyCheck ? (axisStartAccepted | virtualAxisStartAccepted)
                                : virtualAxisStartAccepted;

  always_comb begin
    riseCode = MSC_CODE_NONE;
    if (|realBusy) begin
      riseCode = MSC_CODE_NOT_STOPPED;
    end else if (!mechProgramRegistered) begin
      riseCode = MSC_CODE_PROGRAM;
    end else if (axisNumberMismatch) begin
      riseCode = MSC_CODE_PROGRAM;
    end else if (!controllerRunPermit || !processorReadyDone) begin
      riseCode = MSC_CODE_NOT_READY;
    end else if (!allAxesServoOnCmd) begin
      riseCode = MSC_CODE_SERVO_OFF;
    end
  end

  always_comb begin
    fallCode = MSC_CODE_NONE;
    if ((|virtBusy) || (|(speedTorqueMode & outAxisMask_q))) begin
      fallCode = MSC_CODE_BACK_REAL;
    end
  end

  assign riseFail = riseCode != MSC_CODE_NONE;
  assign fallFail = fallCode != MSC_CODE_NONE;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqPrev_q <= 1'b0;
    end else begin
      reqPrev_q <= modeSwitchRequest;
    end
  end

  // Mode moves only on a clean edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= MSC_REAL;
    end else if (riseEv && !riseFail) begin
      mode_q <= MSC_VIRTUAL;
    end else if (fallEv && !fallFail) begin
      mode_q <= MSC_REAL;
    end
  end
  assign virtualModeActive = mode_q == MSC_VIRTUAL;

  // Success clears the code so software sees the latest outcome
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      switchErrorCode_q <= MSC_CODE_NONE;
    end else if (riseEv) begin
      switchErrorCode_q <= riseCode;
    end else if (fallEv) begin
      switchErrorCode_q <= fallCode;
    end
  end

  // Axis info A only for stop errors, B on any failed drop; never for ready or servo codes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      errorAxisInfoA_q <= '0;
      errorAxisInfoB_q <= '0;
    end else if (riseEv && riseCode == MSC_CODE_NOT_STOPPED) begin
      errorAxisInfoA_q <= realBusy;
    end else if (fallEv && fallFail) begin
      errorAxisInfoB_q <= virtBusy;
    end
  end

  // ==========================================================
  // Interrupts: set wins over clear
  logic [MSC_IRQ_W-1:0] irqSet;
  assign irqSet[MSC_IRQ_DONE] = (riseEv && !riseFail) || (fallEv && !fallFail);
  assign irqSet[MSC_IRQ_ERR] = (riseEv && riseFail) || (fallEv && fallFail);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqStatus_q <= '0;
    end else begin
      irqStatus_q <= (irqStatus_q & ~(wrIrqClr ? (s_axi_wdata[MSC_IRQ_W-1:0] & wrMask[MSC_IRQ_W-1:0]) : '0)) | irqSet;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqEnable_q <= '0;
    end else if (wrIrqEn) begin
      irqEnable_q <= (irqEnable_q & ~wrMask[MSC_IRQ_W-1:0]) | (s_axi_wdata[MSC_IRQ_W-1:0] & wrMask[MSC_IRQ_W-1:0]);
    end
  end
  assign irq = |(irqStatus_q & irqEnable_q);

  // ==========================================================
  // Read path
  logic [31:0] rdMux;
  logic rdKnown;
  always_comb begin
    rdMux = 32'h00000000;
    rdKnown = 1'b1;
    unique case (s_axi_araddr)
      MSC_OFF_CTRL: rdMux[MSC_CTRL_W-1:0] = ctrl_q;
      MSC_OFF_OUT_MASK: rdMux[NUM_AXES-1:0] = outAxisMask_q;
      MSC_OFF_ERR_CODE: rdMux[15:0] = switchErrorCode_q;
      MSC_OFF_ERR_AXIS_A: rdMux[NUM_AXES-1:0] = errorAxisInfoA_q;
      MSC_OFF_ERR_AXIS_B: rdMux[NUM_AXES-1:0] = errorAxisInfoB_q;
      MSC_OFF_STATUS: rdMux[0] = virtualModeActive;
      MSC_OFF_IRQ_STAT: rdMux[MSC_IRQ_W-1:0] = irqStatus_q;
      MSC_OFF_IRQ_CLR: rdMux = 32'h00000000;
      MSC_OFF_IRQ_EN: rdMux[MSC_IRQ_W-1:0] = irqEnable_q;
      default: rdKnown = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= MSC_RESP_OKAY;
    end else if (rdFire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdMux;
      rresp_q <= rdKnown ? MSC_RESP_OKAY : MSC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_RISE_BUSY: assert property (riseEv && |realBusy |=>
      switchErrorCode_q == 16'h0001 && $stable(mode_q))
    else $error("busy output axis did not give code 1");
  AST_FALL_BUSY: assert property (fallEv && |virtBusy |=>
      switchErrorCode_q == 16'h0100 && $stable(mode_q))
    else $error("busy virtual axis did not give code 256");
  AST_FALL_TORQUE: assert property (fallEv && |(speedTorqueMode & outAxisMask_q) |=>
      switchErrorCode_q == 16'h0100)
    else $error("speed-torque output did not give code 256");
  AST_NO_PROGRAM: assert property (riseEv && !(|realBusy) && !mechProgramRegistered |=>
      switchErrorCode_q == 16'h0200)
    else $error("missing program did not give code 512");
  AST_AXIS_MISMATCH: assert property (riseEv && !(|realBusy) && mechProgramRegistered
      && axisNumberMismatch |=> switchErrorCode_q == 16'h0200)
    else $error("axis mismatch did not give code 512");
  AST_NOT_READY: assert property (riseEv && !(|realBusy) && mechProgramRegistered
      && !axisNumberMismatch && !(controllerRunPermit && processorReadyDone)
      |=> switchErrorCode_q == 16'h0201 && $stable(mode_q))
    else $error("not ready did not give code 513");
  AST_SERVO_OFF: assert property (riseEv && controllerRunPermit && processorReadyDone
      && mechProgramRegistered && !(|realBusy) && !axisNumberMismatch && !allAxesServoOnCmd
      |=> switchErrorCode_q == 16'h0202)
    else $error("servo off did not give code 514");
  AST_INVOLVED_ONLY: assert property (riseEv && !legacyCheck
      && (axisStartAccepted & outAxisMask_q) == '0 |=> switchErrorCode_q != 16'h0001)
    else $error("uninvolved axis blocked the switch");
  AST_AXIS_INFO_KEPT: assert property (riseEv && riseCode inside {16'h0201, 16'h0202}
      |=> $stable(errorAxisInfoA_q) && $stable(errorAxisInfoB_q))
    else $error("axis info written on ready or servo error");
  AST_EDGE_ONLY: assert property (!riseEv && !fallEv
      |=> $stable(switchErrorCode_q) && $stable(mode_q))
    else $error("state changed without a request edge");
  AST_RISE_OK: assert property (riseEv && !riseFail ##1 !fallEv
      |=> virtualModeActive && switchErrorCode_q == 16'h0000)
    else $error("clean rise did not enter virtual mode");
  AST_FALL_OK: assert property (fallEv && !(|virtBusy)
      && !(|(speedTorqueMode & outAxisMask_q))
      |=> !virtualModeActive && switchErrorCode_q == 16'h0000)
    else $error("clean drop did not return to real mode");
  AST_INFO_A_SET: assert property (riseEv && |realBusy
      |=> errorAxisInfoA_q == $past(realBusy))
    else $error("busy output axes not recorded");
  AST_INFO_B_SET: assert property (fallEv && |virtBusy
      |=> errorAxisInfoB_q == $past(virtBusy))
    else $error("busy virtual axes not recorded");

  COV_ENTER: cover property (riseEv && !riseFail ##1 virtualModeActive);
  COV_LEAVE: cover property (fallEv && !fallFail ##1 !virtualModeActive);
  COV_BLOCKED: cover property (riseEv && |realBusy);
  COV_IRQ: cover property (irq && wrIrqClr);
endmodule
`default_nettype wire

// ---- verif/msc_motion_model.sv ----
// Motion core model: start-accepted flags, control mode and readiness.
// Assumes the bench sets the wanted state; outputs follow one edge later.
`timescale 1ns/1ps
`default_nettype none
module msc_motion_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Wanted state from the bench
  input wire logic [31:0] realBusy,
  input wire logic [31:0] virtBusy,
  input wire logic [31:0] torqueCtl,
  input wire logic [2:0] flags,
  // Toward the checker
  output logic [31:0] axisStartAccepted,
  output logic [31:0] virtualAxisStartAccepted,
  output logic [31:0] speedTorqueMode,
  output logic processorReadyDone,
  output logic mechProgramRegistered,
  output logic axisNumberMismatch
);
  // ==========================================================
  // Axis state, idle out of reset so toggles start clean
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      axisStartAccepted <= 32'h0;
      virtualAxisStartAccepted <= 32'h0;
      speedTorqueMode <= 32'h0;
    end else begin
      axisStartAccepted <= realBusy;
      virtualAxisStartAccepted <= virtBusy;
      speedTorqueMode <= torqueCtl;
    end
  end
  // ==========================================================
  // Flags: ready, program present, axis number mismatch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      processorReadyDone <= 1'b0;
      mechProgramRegistered <= 1'b0;
      axisNumberMismatch <= 1'b0;
    end else begin
      processorReadyDone <= flags[2];
      mechProgramRegistered <= flags[1];
      axisNumberMismatch <= flags[0];
    end
  end
endmodule
`default_nettype wire

// ---- verif/mode_switch_checker_test.sv ----
// Bench for the mode switch checker: AXI4-Lite master tasks and scenarios.
// Assumes msc_motion_model supplies the motion core state.
`timescale 1ns/1ps
`default_nettype none
module mode_switch_checker_test
  import msc_pkg::*;
;
  logic clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rdy, prog, mism, virtModeActive, irq;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rBusy, vBusy, stm, axR, axV, stmC;
  logic [1:0] bresp, rresp;
  logic [2:0] fl;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [3:0] tCtrl [7] = '{4'h7, 4'h7, 4'h3, 4'h5, 4'h7, 4'h7, 4'h7};
  logic [2:0] tFl [7] = '{3'h6, 3'h4, 3'h6, 3'h6, 3'h2, 3'h4, 3'h7};
  logic [31:0] tBusy [7] = '{32'h80000000, 32'h00000001, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [15:0] tCode [7] = '{MSC_CODE_NOT_STOPPED, MSC_CODE_NOT_STOPPED, MSC_CODE_SERVO_OFF,
    MSC_CODE_NOT_READY, MSC_CODE_NOT_READY, MSC_CODE_PROGRAM, MSC_CODE_PROGRAM};

  msc_mode_switch_checker #(.NUM_AXES(32)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .axisStartAccepted(axR), .virtualAxisStartAccepted(axV), .speedTorqueMode(stmC),
    .processorReadyDone(rdy), .mechProgramRegistered(prog), .axisNumberMismatch(mism),
    .virtualModeActive(virtModeActive), .irq(irq));
  msc_motion_model i_core (.clk(clk), .sys_rst(sys_rst), .realBusy(rBusy), .virtBusy(vBusy),
    .torqueCtl(stm), .flags(fl), .axisStartAccepted(axR), .virtualAxisStartAccepted(axV),
    .speedTorqueMode(stmC), .processorReadyDone(rdy), .mechProgramRegistered(prog),
    .axisNumberMismatch(mism));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // Verdict and hang guard
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // ==========================================================
  // Bus tasks; ready sampled at the negedge, stable until the next edge
  task automatic axiWr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge clk); while (!(awready === 1'b1 && wready === 1'b1));
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge clk); while (bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er,
                    input string nm);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    chk(nm, exp, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge clk);
    rready <= 1'b0;
  endtask
  // Request write; result lands one edge after the write is taken
  task automatic sw(input logic [31:0] c);
    axiWr(MSC_OFF_CTRL, c, MSC_RESP_OKAY);
    repeat (3) @(posedge clk);
  endtask
  task automatic err(input logic [15:0] c);
    rd(MSC_OFF_ERR_CODE, {16'h0, c}, MSC_RESP_OKAY, "errCode");
  endtask
  task automatic vm(input logic m);
    rd(MSC_OFF_STATUS, {31'h0, m}, MSC_RESP_OKAY, "status");
    chk("virtMode", {31'h0, m}, {31'h0, virtModeActive});
  endtask
  task automatic ist(input logic [1:0] s, input logic i);
    rd(MSC_OFF_IRQ_STAT, {30'h0, s}, MSC_RESP_OKAY, "irqStat");
    chk("irq", {31'h0, i}, {31'h0, irq});
  endtask
  task automatic clr();
    axiWr(MSC_OFF_IRQ_CLR, 32'h3, MSC_RESP_OKAY);
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    sys_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, rBusy, vBusy, stm, fl} = '0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(MSC_OFF_CTRL, 32'h0, MSC_RESP_OKAY, "ctrl");
    rd(MSC_OFF_OUT_MASK, MSC_MASK_RST, MSC_RESP_OKAY, "outMask");
    rd(6'h24, 32'h0, MSC_RESP_SLVERR, "unmapped");
    axiWr(6'h24, 32'h1, MSC_RESP_SLVERR);
    axiWr(MSC_OFF_ERR_CODE, 32'hFFFF, MSC_RESP_OKAY);
    err(MSC_CODE_NONE);
    vm(1'b0);
    axiWr(MSC_OFF_IRQ_EN, 32'h3, MSC_RESP_OKAY);
    // Failing rises: busy axes first, so later codes must keep that axis record
    for (int i = 0; i < 7; i++) begin
      rBusy <= tBusy[i];
      fl <= tFl[i];
      sw({28'h0, tCtrl[i]});
      err(tCode[i]);
      vm(1'b0);
      rd(MSC_OFF_ERR_AXIS_A, (tCode[i] == 16'h0001) ? tBusy[i] : 32'h00000001, MSC_RESP_OKAY,
         "axisA");
      sw({28'h0, tCtrl[i]} & 32'hE);
    end
    clr();
    ist(2'h0, 1'b0);
    // Busy axis outside the program does not block the switch
    axiWr(MSC_OFF_OUT_MASK, 32'hFFFFFFF7, MSC_RESP_OKAY);
    rBusy <= 32'h8;
    fl <= 3'h6;
    sw(32'h7);
    err(MSC_CODE_NONE);
    vm(1'b1);
    ist(2'h1, 1'b1);
    axiWr(MSC_OFF_IRQ_EN, 32'h2, MSC_RESP_OKAY);
    ist(2'h1, 1'b0);
    axiWr(MSC_OFF_IRQ_EN, 32'h3, MSC_RESP_OKAY);
    clr();
    // Drop with a busy virtual axis
    vBusy <= 32'h1;
    sw(32'h6);
    err(MSC_CODE_BACK_REAL);
    vm(1'b1);
    rd(MSC_OFF_ERR_AXIS_B, 32'h1, MSC_RESP_OKAY, "axisB");
    ist(2'h2, 1'b1);
    // No edge on the request bit: nothing re-evaluated
    sw(32'h2);
    err(MSC_CODE_BACK_REAL);
    // Drop under speed-torque control
    vBusy <= 32'h0;
    sw(32'h7);
    stm <= 32'h2;
    sw(32'h6);
    err(MSC_CODE_BACK_REAL);
    vm(1'b1);
    stm <= 32'h0;
    sw(32'h7);
    sw(32'h6);
    err(MSC_CODE_NONE);
    vm(1'b0);
    // Older firmware counts every axis
    sw(32'hF);
    err(MSC_CODE_NOT_STOPPED);
    vm(1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
